// ### rtl/ppf_consts.vh
// Purpose: constants for the parallel port fifo control block
// Assumes: plain register port, one 100 MHz clock
// Notes: offsets are word indices on the local register port
`ifndef PPF_CONSTS_VH
`define PPF_CONSTS_VH
// register offsets
`define PPF_OFS_DATA 3'h0
`define PPF_OFS_STATUS 3'h1
`define PPF_OFS_CONTROL 3'h2
`define PPF_OFS_FIFO 3'h3
`define PPF_OFS_ECR 3'h4
`define PPF_OFS_CFGA 3'h5
`define PPF_OFS_CFGB 3'h6
`define PPF_OFS_ADDRQ 3'h7
// extended control fields
`define PPF_ECR_MODE_HI 7
`define PPF_ECR_MODE_LO 5
`define PPF_ECR_ERRDIS 4
`define PPF_ECR_DMA_ENABLE_BIT 3
`define PPF_ECR_SVC 2
`define PPF_ECR_FULL 1
`define PPF_ECR_EMPTY 0
// reset values
`define PPF_ECR_RST 5'h01
`define PPF_CTRL_RST 8'h00
// modes
`define PPF_MODE_STD 3'h0
`define PPF_MODE_PS2 3'h1
`define PPF_MODE_FIFO 3'h2
`define PPF_MODE_ECP 3'h3
`define PPF_MODE_TEST 3'h6
`define PPF_MODE_CFG 3'h7
// control register bits
`define PPF_CTRL_DIR 5
`define PPF_CTRL_STROBE 0
`define PPF_CTRL_AUTOFD 1
// config bits
`define PPF_CFGA_BOTHIRQ 7
`define PPF_CFGB_COMPRESS 7
`define PPF_CFGB_IRQOK 6
// handshake timing
`define PPF_SETUP_NS 50
`define PPF_SETUP_CYC ((`PPF_SETUP_NS + 9) / 10)
`endif

// ### rtl/ppf_fifo.v
// Purpose: flip-flop queue of port words with a tag bit
// Assumes: single clock, synchronous flush
// Notes: push ignored when full, pop ignored when empty
`timescale 1ns/100ps
`default_nettype none
module ppf_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // clock and reset
  input wire ref_clk_in,
  input wire rst_in,
  // control
  input wire flush_in,
  input wire push_in,
  input wire [WIDTH-1:0] push_data_in,
  input wire pop_in,
  // status
  output wire [WIDTH-1:0] head_out,
  output wire full_out,
  output wire empty_out,
  output wire [AW:0] count_out
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire do_push;
  wire do_pop;
  integer i;

  assign full_out = (cnt_q == DEPTH[AW:0]);
  assign empty_out = (cnt_q == {(AW+1){1'b0}});
  assign count_out = cnt_q;
  assign head_out = mem_q[rd_q];
  assign do_push = push_in && !full_out;
  assign do_pop = pop_in && !empty_out;

  // pointers wrap at depth; depth need not be a power of two
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else if (flush_in) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (do_pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (do_push && !do_pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (do_pop && !do_push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  // storage, no reset needed for data
  always @(posedge ref_clk_in) begin
    for (i = 0; i < DEPTH; i = i + 1) begin
      if (do_push && wr_q == i[AW-1:0]) begin
        mem_q[i] <= push_data_in;
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/ppf_port.v
// Purpose: extended parallel port with fifo, modes and forward handshake
// Assumes: register port strobes one cycle, read data one cycle later
// Notes: byte-wide port words; reverse transfer logic is limited to test mode
// Functional notes
// RULE_01: idle after reset, full reads 0 and empty reads 1.
// RULE_02: writing 0x34 to extended control reads back 0x35.
// RULE_03: writing 0xf4 selects configuration mode, opening both config registers.
// RULE_04: config register A reports port word width of one, two or four bytes.
// RULE_05: config A bit 7 high means fault and service interrupts coexist safely.
// RULE_06: compression bit holds 1 only when compression is supported.
// RULE_07: config B bit 6 reads 0 whenever an interrupt conflict exists.
// RULE_08: interrupt and dma select fields may read as fixed zeros.
// RULE_09: direction bit writable in mode 001 and kept; mode 000 forces forward.
// RULE_10: test mode writes fill the fifo; full after exactly depth words.
// RULE_11: service bit 1 then 0 arms; forward test drain sets it at threshold.
// RULE_12: reverse test filling sets service bit at read threshold.
// RULE_13: selecting mode 001 clears the fifo.
// RULE_14: mode 011 sends data queue and address queue with hardware handshake.
// RULE_15: host waits for empty and busy low before changing mode.
// RULE_16: full and empty never both set; host reports it as an error.
// RULE_17: writing 0x74 sets service bit and error disable, masking interrupts.
// RULE_18: changing the mode discards any queued data.
// RULE_19: host refills full depth when empty, else only write threshold.
// RULE_20: after opening a channel, host leaves extended control at 0x34.
// RULE_21: extended control layout mode, errdis, dma, service, full, empty.
`timescale 1ns/100ps
`default_nettype none
`include "ppf_consts.vh"
module ppf_port #(
  parameter DEPTH = 16,
  parameter AW = 4,
  parameter [7:0] TX_LEVEL = 8'h08,
  parameter [7:0] RX_LEVEL = 8'h08,
  parameter [2:0] WORD_CODE = 3'h1,
  parameter BOTH_IRQ_OK = 1,
  parameter HAS_COMPRESS = 0
) (
  // clock and reset
  input wire ref_clk_in,
  input wire rst_in,
  // register port
  input wire [2:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  // peripheral pins
  input wire busy_in,
  input wire peripheral_error_line_in,
  input wire irq_conflict_in,
  output reg [7:0] pdata_out,
  output reg pdata_oe_out,
  output reg strobe_n_out,
  output reg autofd_n_out,
  // request lines
  output wire service_irq_out,
  output wire dma_request_line_out
);
  // ecr fields and software-owned control
  reg [2:0] mode_q;
  reg error_irq_disable_q;
  reg dma_enable_bit_q;
  reg service_irq_bit_q;
  reg svc_armed_q;
  reg [7:0] ctrl_q;
  reg [7:0] data_q;
  reg compress_q;
  reg [7:0] drained_q;
  // pin synchroniser stages
  reg busy_s1_q;
  reg busy_s2_q;
  reg err_s1_q;
  reg err_s2_q;
  reg cfl_s1_q;
  reg cfl_s2_q;

  // forward handshake state, one-hot
  localparam [3:0] HS_IDLE = 4'h1;
  localparam [3:0] HS_SETUP = 4'h2;
  localparam [3:0] HS_ACK = 4'h4;
  localparam [3:0] HS_DONE = 4'h8;
  reg [3:0] hs_q;
  reg [3:0] hs_d;
  reg [3:0] tmr_q;
  // load is one short of the setup time: the zero count is still setup
  localparam integer SETUP_CYCLES = `PPF_SETUP_CYC;
  localparam [3:0] SETUP_LOAD = SETUP_CYCLES[3:0] - 4'h1;

  // decoded register port strobes and mode
  wire wr_hit_ecr = reg_wr_in && reg_addr_in == `PPF_OFS_ECR;
  wire [2:0] new_mode = reg_wdata_in[`PPF_ECR_MODE_HI:`PPF_ECR_MODE_LO];
  wire mode_change = wr_hit_ecr && new_mode != mode_q;
  wire in_test = mode_q == `PPF_MODE_TEST;
  wire in_ecp = mode_q == `PPF_MODE_ECP;
  wire in_cfg = mode_q == `PPF_MODE_CFG;
  wire reverse = ctrl_q[`PPF_CTRL_DIR];

  // queue interface
  wire [8:0] head;
  wire full;
  wire empty;
  wire [AW:0] count;
  wire push;
  wire pop;
  wire flush;
  wire cpu_pop;
  wire hs_pop;
  wire hs_start;

  // data queue words carry the address tag in bit 8
  assign push = reg_wr_in && (
    (reg_addr_in == `PPF_OFS_FIFO && (in_ecp || in_test)) ||
    (reg_addr_in == `PPF_OFS_ADDRQ && in_ecp)); // [RULE_14] [RULE_10]
  assign cpu_pop = reg_rd_in && reg_addr_in == `PPF_OFS_FIFO && in_test;
  assign hs_pop = hs_q == HS_DONE;
  // head word goes out to the pins as setup begins
  assign hs_start = hs_q == HS_IDLE && hs_d == HS_SETUP;
  assign pop = cpu_pop || hs_pop;
  // mode change and entry to mode 001 both empty the queue
  assign flush = mode_change || (wr_hit_ecr && new_mode == `PPF_MODE_PS2); // [RULE_18] [RULE_13]

  ppf_fifo #(.WIDTH(9), .DEPTH(DEPTH), .AW(AW)) u_fifo (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .flush_in(flush),
    .push_in(push),
    .push_data_in({reg_addr_in == `PPF_OFS_ADDRQ, reg_wdata_in}),
    .pop_in(pop),
    .head_out(head),
    .full_out(full),
    .empty_out(empty),
    .count_out(count)
  );

  assign service_irq_out = service_irq_bit_q == 1'b0 && svc_armed_q && !error_irq_disable_q;
  assign dma_request_line_out = dma_enable_bit_q && !service_irq_bit_q && in_ecp && !full &&
    !reverse;

  // pin synchronisers
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_s1_q <= 1'b0;
      busy_s2_q <= 1'b0;
      err_s1_q <= 1'b1;
      err_s2_q <= 1'b1;
      cfl_s1_q <= 1'b0;
      cfl_s2_q <= 1'b0;
    end else begin
      busy_s1_q <= busy_in;
      busy_s2_q <= busy_s1_q;
      err_s1_q <= peripheral_error_line_in;
      err_s2_q <= err_s1_q;
      cfl_s1_q <= irq_conflict_in;
      cfl_s2_q <= cfl_s1_q;
    end
  end

  // control registers and service bit
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_q <= `PPF_MODE_STD;
      error_irq_disable_q <= 1'b0;
      dma_enable_bit_q <= 1'b0;
      service_irq_bit_q <= 1'b0;
      svc_armed_q <= 1'b0;
      ctrl_q <= `PPF_CTRL_RST;
      data_q <= 8'h00;
      compress_q <= 1'b0;
      drained_q <= 8'h00;
    end else begin
      if (wr_hit_ecr) begin
        mode_q <= new_mode; // [RULE_03] [RULE_21]
        error_irq_disable_q <= reg_wdata_in[`PPF_ECR_ERRDIS]; // [RULE_17]
        dma_enable_bit_q <= reg_wdata_in[`PPF_ECR_DMA_ENABLE_BIT];
        // writing 1 masks; writing 0 after a 1 arms the service event
        svc_armed_q <= service_irq_bit_q && !reg_wdata_in[`PPF_ECR_SVC]; // [RULE_11]
      end
      // hardware set wins over the software clear in the same cycle
      if ((in_test && !reverse && cpu_pop && svc_armed_q && !service_irq_bit_q &&
          !empty && drained_q + 8'h01 == TX_LEVEL) ||
          (in_test && reverse && push && !full && svc_armed_q && !service_irq_bit_q &&
          {{(7-AW){1'b0}}, count} + 8'h01 == RX_LEVEL)) begin
        service_irq_bit_q <= 1'b1; // [RULE_11] [RULE_12]
      end else if (wr_hit_ecr) begin
        service_irq_bit_q <= reg_wdata_in[`PPF_ECR_SVC]; // [RULE_17]
      end
      // words removed since the service bit was armed
      if (wr_hit_ecr) begin
        drained_q <= 8'h00;
      end else if (cpu_pop && !empty) begin
        drained_q <= drained_q + 8'h01;
      end
      if (reg_wr_in && reg_addr_in == `PPF_OFS_CONTROL) begin
        ctrl_q <= reg_wdata_in;
        // only mode 001 may take the reverse setting
        if (mode_q == `PPF_MODE_STD) begin
          ctrl_q[`PPF_CTRL_DIR] <= 1'b0; // [RULE_09]
        end else if (mode_q != `PPF_MODE_PS2) begin
          ctrl_q[`PPF_CTRL_DIR] <= ctrl_q[`PPF_CTRL_DIR]; // [RULE_09]
        end
      end else if (wr_hit_ecr && new_mode == `PPF_MODE_STD) begin
        ctrl_q[`PPF_CTRL_DIR] <= 1'b0; // [RULE_09]
      end
      if (reg_wr_in && reg_addr_in == `PPF_OFS_DATA) begin
        data_q <= reg_wdata_in;
      end
      if (reg_wr_in && reg_addr_in == `PPF_OFS_CFGB && in_cfg) begin
        compress_q <= (HAS_COMPRESS != 0) && reg_wdata_in[`PPF_CFGB_COMPRESS]; // [RULE_06]
      end
    end
  end

  // forward handshake next state; host waits for a queued word and busy low
  always @* begin
    hs_d = hs_q;
    case (hs_q)
      HS_IDLE: begin
        if (in_ecp && !reverse && !empty && !busy_s2_q) begin
          hs_d = HS_SETUP; // [RULE_14] [RULE_15]
        end
      end
      HS_SETUP: begin
        if (tmr_q == 4'h0) begin
          hs_d = HS_ACK;
        end
      end
      HS_ACK: begin
        if (busy_s2_q) begin
          hs_d = HS_DONE;
        end
      end
      HS_DONE: begin
        hs_d = HS_IDLE;
      end
      default: begin
        hs_d = HS_IDLE;
      end
    endcase
    if (flush) begin
      hs_d = HS_IDLE;
    end
  end

  // setup timer: loaded as the word goes out, runs down to zero
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tmr_q <= 4'h0;
    end else if (hs_start) begin
      tmr_q <= SETUP_LOAD;
    end else if (tmr_q != 4'h0) begin
      tmr_q <= tmr_q - 4'h1;
    end
  end

  // pins: data, strobe low while waiting for busy, autofd marks address words
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      hs_q <= HS_IDLE;
      pdata_out <= 8'h00;
      pdata_oe_out <= 1'b1;
      strobe_n_out <= 1'b1;
      autofd_n_out <= 1'b1;
    end else begin
      hs_q <= hs_d;
      pdata_oe_out <= !reverse;
      if (hs_start) begin
        pdata_out <= head[7:0];
        autofd_n_out <= !head[8]; // [RULE_14]
      end
      if (hs_q == HS_IDLE && !in_ecp) begin
        pdata_out <= data_q;
        autofd_n_out <= !ctrl_q[`PPF_CTRL_AUTOFD];
      end
      strobe_n_out <= (hs_d == HS_ACK) ? 1'b0 :
        (in_ecp ? 1'b1 : !ctrl_q[`PPF_CTRL_STROBE]);
    end
  end

  // register read mux; flags are status and ignore writes
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `PPF_OFS_DATA: reg_rdata_out <= data_q;
        `PPF_OFS_STATUS: reg_rdata_out <= {!busy_s2_q, 3'h0, err_s2_q, 3'h0};
        `PPF_OFS_CONTROL: reg_rdata_out <= ctrl_q;
        `PPF_OFS_FIFO: reg_rdata_out <= in_test ? head[7:0] : 8'h00;
        `PPF_OFS_ECR: reg_rdata_out <= {mode_q, error_irq_disable_q, dma_enable_bit_q,
          service_irq_bit_q, full, empty}; // [RULE_01] [RULE_02] [RULE_16] [RULE_21]
        `PPF_OFS_CFGA: reg_rdata_out <= in_cfg ?
          {(BOTH_IRQ_OK != 0), WORD_CODE, 4'h0} : 8'h00; // [RULE_03] [RULE_04] [RULE_05]
        // select fields read zero: no routing resources here
        `PPF_OFS_CFGB: reg_rdata_out <= in_cfg ?
          {compress_q, !cfl_s2_q, 6'h00} : 8'h00; // [RULE_06] [RULE_07] [RULE_08]
        default: reg_rdata_out <= 8'h00;
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// ### sim/ppf_monitor.sv
// Purpose: port checker for ppf_port
// Assumes: default parameters, one clock domain
// Notes: mirrors the written ecr to judge read data and request lines
`timescale 1ns/100ps
`default_nettype none
`include "ppf_consts.vh"
module ppf_monitor (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // register port
  input wire logic [2:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // peripheral side
  input wire logic busy_in,
  input wire logic [7:0] pdata_out,
  input wire logic strobe_n_out,
  input wire logic autofd_n_out,
  input wire logic service_irq_out,
  input wire logic dma_request_line_out
);
  logic [7:0] ecr_q;
  logic rd_e;
  logic cfg_on;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // written ecr only; hardware moves the low flags, so compare the top
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) ecr_q <= 8'h00;
    else if (reg_wr_in && reg_addr_in == `PPF_OFS_ECR) ecr_q <= reg_wdata_in;
  end
  // decoded helpers
  assign rd_e = reg_rd_in && reg_addr_in == `PPF_OFS_ECR;
  assign cfg_on = ecr_q[7:5] == `PPF_MODE_CFG;
  property p_echo; rd_e |=> reg_rdata_out[7:3] == $past(ecr_q[7:3]); endproperty
  a_echo: assert property (p_echo) else $error("ecr readback differs");
  property p_flags; rd_e |=> !(reg_rdata_out[1] && reg_rdata_out[0]); endproperty
  a_flags: assert property (p_flags) else $error("full and empty both set");
  property p_shut; reg_rd_in && (reg_addr_in == `PPF_OFS_CFGA || reg_addr_in == `PPF_OFS_CFGB)
    && !cfg_on |=> reg_rdata_out == 8'h00; endproperty
  a_shut: assert property (p_shut) else $error("config open outside cfg mode");
  property p_cfga; reg_rd_in && reg_addr_in == `PPF_OFS_CFGA && cfg_on
    |=> reg_rdata_out[7:4] == 4'h9; endproperty
  a_cfga: assert property (p_cfga) else $error("config a width or irq bit");
  property p_cfgb; reg_rd_in && reg_addr_in == `PPF_OFS_CFGB && cfg_on
    |=> !reg_rdata_out[7] && reg_rdata_out[5:0] == 6'h00; endproperty
  a_cfgb: assert property (p_cfgb) else $error("config b fixed bits");
  property p_hold; !strobe_n_out && !busy_in |=> !strobe_n_out; endproperty
  a_hold: assert property (p_hold) else $error("strobe left before busy");
  property p_steady; !strobe_n_out ##1 !strobe_n_out |-> $stable(pdata_out)
    && $stable(autofd_n_out); endproperty
  a_steady: assert property (p_steady) else $error("word moved under strobe");
  property p_end; $fell(strobe_n_out) |-> ##[1:80] strobe_n_out; endproperty
  a_end: assert property (p_end) else $error("strobe stuck low");
  property p_dma; dma_request_line_out |-> ecr_q[7:5] == 3'h3 && ecr_q[3] && !ecr_q[2];
  endproperty
  a_dma: assert property (p_dma) else $error("dma request unexpected");
  property p_mask; service_irq_out |-> !ecr_q[4] && !ecr_q[2]; endproperty
  a_mask: assert property (p_mask) else $error("irq while masked");
  // main scenarios reached
  c_cfg: cover property (reg_rd_in && reg_addr_in == `PPF_OFS_CFGA && cfg_on);
  c_link: cover property ($fell(strobe_n_out));
  c_dma: cover property (dma_request_line_out);
endmodule
`default_nettype wire

// ### sim/ppf_periph.sv
// Purpose: peripheral model for the forward link
// Assumes: host holds the word steady while strobe is low
// Notes: lag sets how slowly busy answers, at least one cycle
`timescale 1ns/100ps
`default_nettype none
module ppf_periph (
  // host pins
  input wire logic ref_clk_in,
  input wire logic strobe_n_in,
  input wire logic autofd_n_in,
  input wire logic [7:0] pdata_in,
  // pacing
  input wire logic [7:0] lag_in,
  // handshake
  output logic busy_out
);
  logic [8:0] rx_q[$];
  // take word lag cycles after strobe falls, keep busy until lag cycles after strobe is released; one process drives busy
  initial begin
    busy_out = 1'b0;
    forever begin
      @(negedge strobe_n_in);
      repeat (lag_in) @(posedge ref_clk_in);
      rx_q.push_back({autofd_n_in, pdata_in});
      busy_out <= 1'b1;
      @(posedge strobe_n_in);
      repeat (lag_in) @(posedge ref_clk_in);
      busy_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### sim/tb.sv
// Purpose: self-checking bench for ppf_port
// Assumes: default depth 16 and both levels 8
// Notes: random bytes from a fixed lfsr seed
`timescale 1ns/100ps
`default_nettype none
`include "ppf_consts.vh"
module tb;
  logic clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, conf = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, rdata, pdata, lag = 8'h01, d;
  logic busy, strobe_n, autofd_n, svc_irq, dma, oe;
  logic [31:0] seed = 32'h6c00;
  logic [8:0] q[$];
  int fail_count = 0, total_checks = 0, cyc = 0, i, j, k;
  ppf_port dut (.ref_clk_in(clk), .rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata), .busy_in(busy),
    .peripheral_error_line_in(1'b1), .irq_conflict_in(conf), .pdata_out(pdata),
    .pdata_oe_out(oe), .strobe_n_out(strobe_n), .autofd_n_out(autofd_n),
    .service_irq_out(svc_irq), .dma_request_line_out(dma));
  ppf_periph per (.ref_clk_in(clk), .strobe_n_in(strobe_n), .autofd_n_in(autofd_n),
    .pdata_in(pdata), .lag_in(lag), .busy_out(busy));
  always #5 clk = ~clk;
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // service bit expected once 8 words have moved
  function automatic logic [7:0] hit(input int n);
    return (n >= 8) ? 8'h04 : 8'h00;
  endfunction
  task automatic give_verdict;
    if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string n, input logic [8:0] g, input logic [8:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // one-cycle strobes, changed just after the edge
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] m, e, input string n);
    logic [7:0] v;
    rd(a, v);
    chk(n, {1'b0, v & m}, {1'b0, e});
  endtask
  // hang guard well above the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rdc(`PPF_OFS_ECR, 8'h03, 8'h01, "idle_flags");
    wr(`PPF_OFS_ECR, 8'h34);
    rdc(`PPF_OFS_ECR, 8'hFF, 8'h35, "ecr_34");
    rdc(`PPF_OFS_CFGA, 8'hFF, 8'h00, "cfg_closed");
    wr(`PPF_OFS_ECR, 8'hF4);
    rdc(`PPF_OFS_CFGA, 8'hF0, 8'h90, "cfg_a");
    wr(`PPF_OFS_CFGB, 8'hFF);
    for (i = 0; i < 2; i++) begin
      conf <= i[0];
      repeat (4) @(posedge clk);
      rdc(`PPF_OFS_CFGB, 8'hFF, {1'b0, ~i[0], 6'h00}, "cfg_b");
    end
    // direction kept from 001, forced forward in 000
    wr(`PPF_OFS_ECR, 8'h34);
    wr(`PPF_OFS_CONTROL, 8'h20);
    wr(`PPF_OFS_ECR, 8'h74);
    rdc(`PPF_OFS_CONTROL, 8'h20, 8'h20, "dir_kept");
    wr(`PPF_OFS_ECR, 8'h14);
    rdc(`PPF_OFS_CONTROL, 8'h20, 8'h00, "dir_std");
    wr(`PPF_OFS_ECR, 8'h34);
    wr(`PPF_OFS_CONTROL, 8'h00);
    // forward test: fill to full, then drain past the level
    wr(`PPF_OFS_ECR, 8'hC4);
    for (i = 0; i < 16; i++) begin
      rdc(`PPF_OFS_ECR, 8'h03, (i == 0) ? 8'h01 : 8'h00, "fill");
      seed = nxt(seed);
      q.push_back({1'b0, seed[7:0]});
      wr(`PPF_OFS_FIFO, seed[7:0]);
    end
    rdc(`PPF_OFS_ECR, 8'h03, 8'h02, "full");
    wr(`PPF_OFS_ECR, 8'hC0);
    for (i = 1; i <= 12; i++) begin
      rdc(`PPF_OFS_FIFO, 8'hFF, 8'(q.pop_front()), "pop");
      rdc(`PPF_OFS_ECR, 8'h04, hit(i), "tx_level");
    end
    q.delete();
    wr(`PPF_OFS_ECR, 8'h34);
    rdc(`PPF_OFS_ECR, 8'hFF, 8'h35, "flushed");
    // reverse test: level reached while filling
    wr(`PPF_OFS_CONTROL, 8'h20);
    wr(`PPF_OFS_ECR, 8'hD4);
    wr(`PPF_OFS_ECR, 8'hD0);
    for (i = 1; i <= 10; i++) begin
      seed = nxt(seed);
      wr(`PPF_OFS_FIFO, seed[7:0]);
      rdc(`PPF_OFS_ECR, 8'h04, hit(i), "rx_level");
    end
    wr(`PPF_OFS_ECR, 8'h74);
    rdc(`PPF_OFS_ECR, 8'hFF, 8'h75, "masked");
    chk("oe_rev", {8'h00, oe}, 9'h000);
    wr(`PPF_OFS_ECR, 8'h34);
    wr(`PPF_OFS_CONTROL, 8'h00);
    wr(`PPF_OFS_ECR, 8'h68);
    #1 chk("dma_req", {8'h00, dma}, 9'h001);
    chk("svc_on", {8'h00, svc_irq}, 9'h001);
    wr(`PPF_OFS_ECR, 8'h74);
    #1 chk("svc_off", {8'h00, svc_irq}, 9'h000);
    chk("dma_off", {8'h00, dma}, 9'h000);
    // forward link, quick then slow peripheral, data and addresses mixed
    for (j = 0; j < 2; j++) begin
      lag <= (j == 0) ? 8'd1 : 8'd9;
      for (i = 0; i < 6; i++) begin // empty queue takes up to depth
        seed = nxt(seed);
        if (seed[8]) q.push_back({2'b00, seed[6:0]});
        else q.push_back({1'b1, seed[7:0]});
        wr(seed[8] ? `PPF_OFS_ADDRQ : `PPF_OFS_FIFO, seed[8] ? {1'b0, seed[6:0]} : seed[7:0]);
      end
      k = 0;
      do begin
        rd(`PPF_OFS_ECR, d);
        k++;
      end while (!(d[0] === 1'b1 && busy === 1'b0) && k < 300);
      chk("drained", {8'h00, d[0]}, 9'h001);
      chk("oe_fwd", {8'h00, oe}, 9'h001);
      while (q.size() > 0) chk("link", per.rx_q.pop_front(), q.pop_front());
      chk("extra", 9'(per.rx_q.size()), 9'h000);
    end
    give_verdict;
  end
endmodule
bind ppf_port ppf_monitor mon (.ref_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in,
  .reg_wr_in, .reg_rd_in, .reg_rdata_out, .busy_in, .pdata_out, .strobe_n_out,
  .autofd_n_out, .service_irq_out, .dma_request_line_out);
`default_nettype wire
